// *** design/audio_port_ctrl.sv ***
// Global control, link front end and interrupt logic of the audio port.
//
// Chosen here: the address map and strobed register access.
`timescale 1ns/1ps
module audio_port_ctrl #(
  parameter int unsigned DIV = audio_port_pkg::BCLK_DIV
) (
  input  wire logic                    mclk,                 // Block clock, 25 MHz.
  input  wire logic                    rst_n,                // Asynchronous reset.
  input  wire audio_port_pkg::bus_req_t bus_req,             // Register request.
  output logic [15:0]                  rd_data,              // Read data, next cycle.
  input  wire logic                    tx_almost_empty_flag, // Transmit buffer low.
  input  wire logic                    tx_underrun_flag,     // Transmit underrun.
  input  wire logic                    rx_irq_event,         // Receive service request.
  input  wire logic                    rx_err_event,         // Receive error.
  input  wire logic                    link_bclk,            // Bit clock pin.
  input  wire logic                    link_fsync,           // Frame sync pin.
  output audio_port_pkg::cfg_t         mode_cfg,             // Configuration copy.
  output logic                         port_clk_en,          // Port clock gate.
  output logic                         port_enable,          // Port on.
  output logic                         slave_mode,           // ISDN slave mode.
  output logic                         ext_bclk,             // Bit clock from pin.
  output logic                         ext_fsync,            // Frame sync from pin.
  output logic                         rx_fifo_clear,        // Receive FIFO reset.
  output logic                         tx_fifo_clear,        // Transmit FIFO reset.
  output logic                         bit_tick,             // Bit clock enable.
  output logic                         frame_start,          // Frame start pulse.
  output logic                         audio_irq             // Interrupt request.
);

  // ********************************************************************
  // State
  // ********************************************************************
  typedef struct packed {
    audio_port_pkg::cfg_t cfg;
    logic [3:0]           irq_en;
    logic [3:0]           evt;
    logic [3:0]           mask;
    logic [15:0]          rdata;
    logic [7:0]           div_cnt;
    logic                 bit_tick;
    logic                 frame_start;
    logic                 tx_almost_empty_flag_prev;
    logic                 tx_ur_prev;
  } ctrl_state_t;

  ctrl_state_t s_q;
  ctrl_state_t s_d;

  logic [1:0] pin_rise;
  logic [1:0] pin_fall;
  logic [3:0] pend;
  logic [3:0] pend_set;
  logic [3:0] pend_clr;
  logic       wr_cfg;
  logic       wr_irq;
  logic       running;
  logic       ext_bclk_eff;
  logic       ext_fs_eff;
  logic       fs_edge;
  audio_port_pkg::cfg_t wcfg;
  audio_port_pkg::irq_t wirq;
  audio_port_pkg::irq_t irq_view;

  // ********************************************************************
  // Link pin synchroniser
  // ********************************************************************
  link_sync #(
    .W (2)
  ) u_link_sync (
    .mclk  (mclk),
    .rst_n (rst_n),
    .pin   ({link_fsync, link_bclk}),
    .lvl   (),
    .rise  (pin_rise),
    .fall  (pin_fall)
  );

  // ********************************************************************
  // Decode and derived controls
  // ********************************************************************
  // Register writes and the modes they select.
  always_comb
  begin
    wcfg         = audio_port_pkg::cfg_t'(bus_req.wdata);
    wirq         = audio_port_pkg::irq_t'(bus_req.wdata);
    wr_cfg       = bus_req.wr && (bus_req.addr == audio_port_pkg::OFS_CFG);
    wr_irq       = bus_req.wr && (bus_req.addr == audio_port_pkg::OFS_IRQ)
                   && s_q.cfg.module_clock_enable;
    running      = s_q.cfg.module_clock_enable && s_q.cfg.module_enable_bit;
    ext_bclk_eff = s_q.cfg.ext_bclk || s_q.cfg.isdn_slave_mode_sel;
    ext_fs_eff   = s_q.cfg.ext_fs || s_q.cfg.isdn_slave_mode_sel;
    fs_edge      = s_q.cfg.fs_invert ? pin_fall[1] : pin_rise[1];
  end

  // Pending flag sets and write-one clears, order rx, rx error, tx, tx error.
  always_comb
  begin
    pend_set[0] = running && s_q.irq_en[0] && rx_irq_event;
    pend_set[1] = running && s_q.irq_en[1] && rx_err_event;
    pend_set[2] = running && s_q.irq_en[2] && tx_almost_empty_flag;
    pend_set[3] = running && s_q.irq_en[3] && tx_underrun_flag;
    pend_clr    = wr_irq ? {wirq.tx_err_irq_clear, wirq.tx_irq_clear,
                            wirq.rx_err_irq_clear, wirq.rx_irq_clear} : 4'h0;
  end

  // ********************************************************************
  // Pending flags
  // ********************************************************************
  // Each flag clears only through its own clear bit.
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_pend
      pend_flag u_pend (
        .mclk  (mclk),
        .rst_n (rst_n),
        .set   (pend_set[gi]),
        .clr   (pend_clr[gi]),
        .pend  (pend[gi])
      );
    end
  endgenerate

  // Read view of the interrupt register; clear bits read as zero.
  always_comb
  begin
    irq_view                    = '0;
    irq_view.rx_irq_enable      = s_q.irq_en[0];
    irq_view.rx_err_irq_enable  = s_q.irq_en[1];
    irq_view.tx_irq_enable      = s_q.irq_en[2];
    irq_view.tx_err_irq_enable  = s_q.irq_en[3];
    irq_view.rx_irq_pending     = pend[0];
    irq_view.rx_err_irq_pending = pend[1];
    irq_view.tx_irq_pending     = pend[2];
    irq_view.tx_err_irq_pending = pend[3];
  end

  // ********************************************************************
  // Next state
  // ********************************************************************
  always_comb
  begin
    s_d                 = s_q;
    s_d.cfg.clr_rx_fifo = 1'b0;
    s_d.cfg.clr_tx_fifo = 1'b0;
    s_d.rdata           = 16'h0000;
    s_d.bit_tick        = 1'b0;
    s_d.frame_start     = 1'b0;
    s_d.tx_almost_empty_flag_prev      = tx_almost_empty_flag;
    s_d.tx_ur_prev      = tx_underrun_flag;
    // Configuration write: clock enable first, mode bits locked while on.
    if (wr_cfg)
    begin
      if (!s_q.cfg.module_clock_enable)
      begin
        s_d.cfg                     = '0;
        s_d.cfg.module_clock_enable = wcfg.module_clock_enable;
      end
      else if (s_q.cfg.module_enable_bit)
      begin
        s_d.cfg.module_clock_enable = wcfg.module_clock_enable;
        s_d.cfg.module_enable_bit   = wcfg.module_enable_bit;
        s_d.cfg.clr_rx_fifo         = wcfg.clr_rx_fifo;
        s_d.cfg.clr_tx_fifo         = wcfg.clr_tx_fifo;
      end
      else
      begin
        s_d.cfg = wcfg;
      end
    end
    // Interrupt enables.
    if (wr_irq)
    begin
      s_d.irq_en = {wirq.tx_err_irq_enable, wirq.tx_irq_enable,
                    wirq.rx_err_irq_enable, wirq.rx_irq_enable};
    end
    if (bus_req.wr && bus_req.addr == audio_port_pkg::OFS_MASK
        && s_q.cfg.module_clock_enable)
    begin
      s_d.mask = bus_req.wdata[3:0];
    end
    // Read data, valid only in the cycle after the strobe.
    if (bus_req.rd)
    begin
      case (bus_req.addr)
        audio_port_pkg::OFS_CFG:
          s_d.rdata = s_q.cfg;
        audio_port_pkg::OFS_IRQ:
          s_d.rdata = s_q.cfg.module_clock_enable ? irq_view : 16'h0000;
        audio_port_pkg::OFS_EVT:
        begin
          s_d.rdata = s_q.cfg.module_clock_enable ? {12'h000, s_q.evt} : 16'h0000;
          if (s_q.cfg.module_clock_enable)
          begin
            s_d.evt = 4'h0;
          end
        end
        audio_port_pkg::OFS_MASK:
          s_d.rdata = s_q.cfg.module_clock_enable ? {12'h000, s_q.mask} : 16'h0000;
        default:
          s_d.rdata = 16'h0000;
      endcase
    end
    // Bit clock: divider when internal, pin edges when external or slave; no ticks and divider cleared without clock.
    if (s_q.cfg.module_clock_enable)
    begin
      if (s_q.div_cnt == 8'(DIV - 1))
      begin
        s_d.div_cnt = 8'h00;
      end
      else
      begin
        s_d.div_cnt = s_q.div_cnt + 8'h01;
      end
      s_d.bit_tick    = running && (ext_bclk_eff ? pin_rise[0]
                                     : (s_q.div_cnt == 8'(DIV - 1)));
      s_d.frame_start = running && ext_fs_eff && fs_edge;
    end
    else
    begin
      s_d.div_cnt = 8'h00;
    end
    // Sticky events set after any read clear, so a new event wins.
    s_d.evt = s_d.evt | {running && rx_err_event,
                         running && tx_underrun_flag && !s_q.tx_ur_prev,
                         running && tx_almost_empty_flag && !s_q.tx_almost_empty_flag_prev,
                         s_d.frame_start};
  end

  // State register.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q         <= '0;
      s_q.cfg     <= audio_port_pkg::CFG_RST;
      s_q.irq_en  <= audio_port_pkg::IRQ_RST[3:0];
      s_q.evt     <= audio_port_pkg::EVT_RST;
      s_q.mask    <= audio_port_pkg::MASK_RST;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ********************************************************************
  // Outputs
  // ********************************************************************
  assign rd_data       = s_q.rdata;
  assign mode_cfg      = s_q.cfg;
  assign port_clk_en   = s_q.cfg.module_clock_enable;
  assign port_enable   = s_q.cfg.module_enable_bit;
  assign slave_mode    = s_q.cfg.isdn_slave_mode_sel;
  assign ext_bclk      = ext_bclk_eff;
  assign ext_fsync     = ext_fs_eff;
  assign rx_fifo_clear = s_q.cfg.clr_rx_fifo;
  assign tx_fifo_clear = s_q.cfg.clr_tx_fifo;
  assign bit_tick      = s_q.bit_tick;
  assign frame_start   = s_q.frame_start;
  assign audio_irq     = |(pend & s_q.irq_en) | |(s_q.evt & s_q.mask);

  // ********************************************************************
  // Assertions
  // ********************************************************************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  // Configuration access, mode and clock checks.
  AST_MODE_SEL: assert property (wr_cfg && port_clk_en && !port_enable |=>
    slave_mode == $past(bus_req.wdata[13]))
    else $error("Mode select does not follow the write.");
  AST_SLAVE_EXT: assert property (slave_mode |-> ext_bclk && ext_fsync)
    else $error("Slave mode without external clock and sync.");
  AST_ENABLE: assert property (wr_cfg && port_clk_en && !port_enable |=>
    port_enable == $past(bus_req.wdata[14]))
    else $error("Module enable does not follow the write.");
  AST_OPEN_ACCESS: assert property (wr_cfg && port_clk_en && !port_enable |=>
    rd_data == 16'h0000 ##0 mode_cfg[7:0] == $past(bus_req.wdata[7:0]))
    else $error("Configuration write not taken while disabled.");
  AST_NO_ACCESS: assert property (bus_req.rd && !port_clk_en
    && bus_req.addr != audio_port_pkg::OFS_CFG |=> rd_data == 16'h0000)
    else $error("Register readable without clock enable.");
  AST_MODULE_CLOCK_ENABLE_FIRST: assert property (wr_cfg && !port_clk_en |=>
    mode_cfg[14:0] == 15'h0000)
    else $error("Configuration bit set before clock enable.");
  AST_CLK_STOP: assert property (!port_clk_en |=> !bit_tick[*2])
    else $error("Bit clock runs while clock is stopped.");

  // Pending flag and interrupt output checks.
  AST_TX_IRQ: assert property (running && s_q.irq_en[2]
    && tx_almost_empty_flag |=> pend[2] && audio_irq)
    else $error("Transmit interrupt not raised.");
  AST_TX_ERR_IRQ: assert property (!pend[3] && !s_q.irq_en[3] |=> !pend[3])
    else $error("Transmit error pends while disabled.");
  AST_RX_HOLD: assert property (pend[0] && !pend_clr[0] |=> pend[0])
    else $error("Receive pending lost without its clear.");
  AST_RX_ERR_HOLD: assert property (pend[1] && !pend_clr[1] |=> pend[1])
    else $error("Receive error pending lost without its clear.");
  AST_TX_CLR: assert property (pend[2] && pend_clr[2] && !pend_set[2] |=> !pend[2])
    else $error("Transmit pending not cleared.");
  AST_TX_ERR_HOLD: assert property (pend[3] && !pend_clr[3] |=> pend[3])
    else $error("Transmit error pending lost without its clear.");
  AST_IRQ_OUT: assert property (|(pend & s_q.irq_en) |-> audio_irq)
    else $error("Enabled pending flag without interrupt.");

  // Read data return to zero in every cycle without a read strobe.
  AST_RD_IDLE: assert property (!bus_req.rd |=> rd_data == 16'h0000)
    else $error("Read data present without a read strobe.");
  // A port that is off produces neither bit ticks nor frame starts.
  AST_TICK_GATED: assert property (!running |=> !bit_tick && !frame_start)
    else $error("Link pulse while the port is off.");
  // FIFO clear bits pulse for the one cycle after an accepted write.
  AST_FIFO_CLR: assert property (wr_cfg && port_clk_en |=>
    rx_fifo_clear == $past(bus_req.wdata[8])
    && tx_fifo_clear == $past(bus_req.wdata[9]))
    else $error("FIFO clear bits do not follow the write.");
  // Clear bits and reserved bits of the interrupt register read as zero.
  AST_CLR_READ_ZERO: assert property (bus_req.rd
    && bus_req.addr == audio_port_pkg::OFS_IRQ |=> rd_data[15:8] == 8'h00)
    else $error("Interrupt clear bits do not read as zero.");

  // Coverage of the main scenarios.
  COV_SLAVE_FRAME: cover property (slave_mode && frame_start);
  COV_TX_IRQ_CLEAR: cover property (pend[2] ##1 pend_clr[2] ##1 !pend[2]);
  COV_ENABLE_SEQ: cover property (!port_clk_en ##1 port_clk_en ##[1:64] port_enable);

endmodule

// *** design/audio_port_pkg.sv ***
// Shared constants and types of the audio port global control block.
package audio_port_pkg;

  // ********************************************************************
  // Bus and register map
  // ********************************************************************
  localparam int unsigned ADDR_W   = 4;
  localparam int unsigned DATA_W   = 16;
  localparam logic [3:0]  OFS_CFG  = 4'h0;  // Global configuration.
  localparam logic [3:0]  OFS_IRQ  = 4'h4;  // Interrupt status and control.
  localparam logic [3:0]  OFS_EVT  = 4'h8;  // Sticky event status, cleared by read.
  localparam logic [3:0]  OFS_MASK = 4'hc;  // Event mask.

  // ********************************************************************
  // Reset values
  // ********************************************************************
  localparam logic [15:0] CFG_RST  = 16'h0000;
  localparam logic [15:0] IRQ_RST  = 16'h0000;
  localparam logic [3:0]  EVT_RST  = 4'h0;
  localparam logic [3:0]  MASK_RST = 4'h0;

  // ********************************************************************
  // Timing
  // ********************************************************************
  localparam int unsigned CLK_PERIOD_NS  = 40;
  localparam int unsigned BCLK_PERIOD_NS = 320;  // Internal bit clock period.
  localparam int unsigned BCLK_DIV       = BCLK_PERIOD_NS / CLK_PERIOD_NS;

  // ********************************************************************
  // Register layouts, most significant field first
  // ********************************************************************
  typedef struct packed {
    logic       module_clock_enable;  // Bit 15.
    logic       module_enable_bit;    // Bit 14.
    logic       isdn_slave_mode_sel;  // Bit 13.
    logic       fs_invert;            // Bit 12.
    logic [1:0] fs_len;               // Bits 11:10.
    logic       clr_tx_fifo;          // Bit 9.
    logic       clr_rx_fifo;          // Bit 8.
    logic       ext_bclk;             // Bit 7.
    logic       long_fs;              // Bit 6.
    logic       ext_fs;               // Bit 5.
    logic [1:0] slot_cnt;             // Bits 4:3.
    logic       loop_back;            // Bit 2.
    logic       word16;               // Bit 1.
    logic       async_mode;           // Bit 0.
  } cfg_t;

  typedef struct packed {
    logic [3:0] rsvd;                 // Bits 15:12, read as zero.
    logic       tx_err_irq_clear;     // Bit 11.
    logic       tx_irq_clear;         // Bit 10.
    logic       rx_err_irq_clear;     // Bit 9.
    logic       rx_irq_clear;         // Bit 8.
    logic       tx_err_irq_pending;   // Bit 7.
    logic       tx_irq_pending;       // Bit 6.
    logic       rx_err_irq_pending;   // Bit 5.
    logic       rx_irq_pending;       // Bit 4.
    logic       tx_err_irq_enable;    // Bit 3.
    logic       tx_irq_enable;        // Bit 2.
    logic       rx_err_irq_enable;    // Bit 1.
    logic       rx_irq_enable;        // Bit 0.
  } irq_t;

  // Register port request, one cycle per access.
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } bus_req_t;

endpackage

// *** design/link_sync.sv ***
// Two-flop synchroniser with edge detection for link pins.
`timescale 1ns/1ps
module link_sync #(
  parameter int unsigned W = 2
) (
  input  wire logic         mclk,  // Block clock.
  input  wire logic         rst_n, // Asynchronous reset, active low.
  input  wire logic [W-1:0] pin,   // Pins from outside the clock domain.
  output logic      [W-1:0] lvl,   // Synchronised level.
  output logic      [W-1:0] rise,  // One-cycle pulse on a rising edge.
  output logic      [W-1:0] fall   // One-cycle pulse on a falling edge.
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
    logic [W-1:0] prev;
  } sync_state_t;

  sync_state_t s_q;
  sync_state_t s_d;

  // Shift the pins through the chain; the first stage is never observed.
  always_comb
  begin
    s_d      = s_q;
    s_d.meta = pin;
    s_d.sync = s_q.meta;
    s_d.prev = s_q.sync;
  end

  // State register.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // Edge outputs compare the synchronised stage with its delayed copy.
  assign lvl  = s_q.sync;
  assign rise = s_q.sync & ~s_q.prev;
  assign fall = ~s_q.sync & s_q.prev;

endmodule

// *** design/pend_flag.sv ***
// One interrupt pending flag: set by hardware, cleared by a write of one.
`timescale 1ns/1ps
module pend_flag (
  input  wire logic mclk,  // Block clock.
  input  wire logic rst_n, // Asynchronous reset, active low.
  input  wire logic set,   // Hardware event, level or pulse.
  input  wire logic clr,   // Write-one-to-clear strobe.
  output logic      pend   // Pending flag, from a register.
);

  typedef struct packed {
    logic pend;
  } flag_state_t;

  flag_state_t s_q;
  flag_state_t s_d;

  // A set in the clear cycle wins so that no event is lost.
  always_comb
  begin
    s_d = s_q;
    if (set)
    begin
      s_d.pend = 1'b1;
    end
    else if (clr)
    begin
      s_d.pend = 1'b0;
    end
  end

  // State register.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign pend = s_q.pend;

endmodule

// *** tb/link_partner.sv ***
// Behavioural model of the external controller that drives the link pins.
`timescale 1ns/1ps
module link_partner (
  input  wire logic go,    // Start of one frame, from the bench.
  output logic      bclk,  // Bit clock toward the port.
  output logic      fsync  // Frame sync toward the port.
);
  // ********************************************************************
  // Frame generator
  // ********************************************************************
  // The far side owns both link clocks; they stand still low between frames.
  initial
  begin
    bclk  = 1'b0;
    fsync = 1'b0;
    forever
    begin
      wait (go === 1'b1);
      #37;
      for (int i = 0; i < 16; i++)
      begin
        fsync = (i == 0);
        #160 bclk = 1'b1;
        #160 bclk = 1'b0;
      end
      fsync = 1'b0;
    end
  end
endmodule

// *** tb/testbench.sv ***
// Self-checking bench of the audio port global control block.
`timescale 1ns/1ps
module testbench;
  // ********************************************************************
  // Signals
  // ********************************************************************
  logic                     mclk = 1'b0;
  logic                     rst_n = 1'b0;
  audio_port_pkg::bus_req_t bus_req = '0;
  logic [15:0]              rd_data;
  logic [3:0]               src = 4'h0;
  logic                     go = 1'b0;
  logic                     bclk;
  logic                     fsync;
  logic                     audio_irq;
  logic                     clk_en;
  logic                     slave;
  logic                     ext_bc;
  logic                     port_en;
  audio_port_pkg::cfg_t     cfg_out;
  logic                     ext_fs;
  logic                     rx_clr;
  logic                     tx_clr;
  logic                     tick;
  logic                     fstart;
  int                       ticks = 0;
  int                       frames = 0;
  int                       n0 = 0;
  logic [15:0]              exp_q[$];
  logic                     rd_last = 1'b0;
  logic [31:0]              seed = 32'h0000002f;
  int                       err_count = 0;
  int                       tests_run = 0;
  int                       cyc = 0;

  // Clock of 40 ns period.
  always #20 mclk = ~mclk;

  audio_port_ctrl u_audio_port_ctrl (
    .mclk(mclk), .rst_n(rst_n), .bus_req(bus_req), .rd_data(rd_data),
    .tx_almost_empty_flag(src[0]), .tx_underrun_flag(src[1]),
    .rx_irq_event(src[2]), .rx_err_event(src[3]), .link_bclk(bclk),
    .link_fsync(fsync), .mode_cfg(cfg_out), .port_clk_en(clk_en), .port_enable(port_en),
    .slave_mode(slave), .ext_bclk(ext_bc), .ext_fsync(ext_fs), .rx_fifo_clear(rx_clr),
    .tx_fifo_clear(tx_clr), .bit_tick(tick), .frame_start(fstart), .audio_irq(audio_irq));

  link_partner u_link_partner (.go(go), .bclk(bclk), .fsync(fsync));

  // ********************************************************************
  // Helpers
  // ********************************************************************
  // Xorshift generator with a fixed start.
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Counts a comparison and reports a mismatch.
  task automatic cmp(input logic [15:0] got, input logic [15:0] e);
    tests_run++;
    if (got !== e)
    begin
      err_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, e);
    end
  endtask

  // One-cycle register write.
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    bus_req <= '{1'b1, 1'b0, a, d};
    @(posedge mclk);
    bus_req.wr <= 1'b0;
    @(negedge mclk);
  endtask

  // One-cycle register read; the expected word goes to the queue.
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge mclk);
    bus_req <= '{1'b0, 1'b1, a, 16'h0000};
    exp_q.push_back(e);
    @(posedge mclk);
    bus_req.rd <= 1'b0;
    @(negedge mclk);
  endtask

  // Pulses one event source for a single cycle.
  task automatic pulse(input int i);
    @(posedge mclk);
    src[i] <= 1'b1;
    @(posedge mclk);
    src[i] <= 1'b0;
    @(negedge mclk);
  endtask

  // Checks a level output; callers stand at a falling edge, where it has settled.
  task automatic pin(input logic got_sel, input logic e);
    cmp({15'h0000, got_sel}, {15'h0000, e});
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic end_sim();
    $display("errors %0d checks %0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ********************************************************************
  // Read-data monitor and timeout
  // ********************************************************************
  // Read data stand in the cycle after the strobe; the oldest note is compared.
  always @(negedge mclk)
  begin
    if (rd_last)
      cmp(rd_data, exp_q.pop_front());
    rd_last = bus_req.rd;
  end

  // Counts link pulses once they have settled.
  always @(negedge mclk)
  begin
    ticks = ticks + tick;
    frames = frames + fstart;
  end

  // Cuts a hang short.
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      err_count++;
      end_sim();
    end
  end

  // ********************************************************************
  // Main sequence
  // ********************************************************************
  initial
  begin
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    rd(4'h0, 16'h0000);
    rd(4'h4, 16'h0000);
    wr(4'h4, 16'h000f);
    wr(4'h0, 16'h6003);
    rd(4'h0, 16'h0000);
    wr(4'h0, 16'h8000);
    pin(clk_en, 1'b1);
    rd(4'h4, 16'h0000);
    wr(4'h0, 16'ha003);
    rd(4'h0, 16'ha003);
    pin(slave, 1'b1);
    pin(ext_bc, 1'b1);
    wr(4'h4, {8'h00, 8'(rnd()) & 8'hf0} | 16'h000f);
    rd(4'h4, 16'h000f);
    wr(4'h0, 16'he003);
    rd(4'h0, 16'he003);
    pin(port_en, 1'b1);
    pin(ext_fs, 1'b1);
    // FIFO clears pulse once while the mode bits stay locked.
    wr(4'h0, 16'hc300);
    cmp({14'h0000, rx_clr, tx_clr}, 16'h0003);
    cmp(cfg_out, 16'he303);
    @(negedge mclk);
    cmp({14'h0000, rx_clr, tx_clr}, 16'h0000);
    rd(4'h0, 16'he003);
    // One frame from the far side leaves a frame event.
    @(posedge mclk);
    go <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
    repeat (200) @(posedge mclk);
    cmp(16'(ticks), 16'h0010);
    cmp(16'(frames), 16'h0001);
    rd(4'h8, 16'h0001);
    rd(4'h8, 16'h0000);
    // Internal bit clock: one tick every eight cycles while running.
    wr(4'h0, 16'h8000);
    wr(4'h0, 16'hc000);
    pin(ext_bc, 1'b0);
    n0 = ticks;
    repeat (64) @(posedge mclk);
    cmp(16'(ticks - n0), 16'h0008);
    pulse(0);
    pin(audio_irq, 1'b1);
    rd(4'h4, 16'h004f);
    wr(4'h4, 16'h040f);
    rd(4'h4, 16'h000f);
    pin(audio_irq, 1'b0);
    pulse(1);
    rd(4'h4, 16'h008f);
    wr(4'h4, 16'h080f);
    rd(4'h4, 16'h000f);
    pulse(2);
    rd(4'h4, 16'h001f);
    wr(4'h4, 16'h020f);
    rd(4'h4, 16'h001f);
    wr(4'h4, 16'h010f);
    rd(4'h4, 16'h000f);
    pulse(3);
    pin(audio_irq, 1'b1);
    rd(4'h4, 16'h002f);
    wr(4'h4, 16'h020f);
    rd(4'h4, 16'h000f);
    rd(4'h8, 16'h000e);
    wr(4'h4, 16'h0000);
    pulse(0);
    pin(audio_irq, 1'b0);
    rd(4'h4, 16'h0000);
    wr(4'hc, 16'h0002);
    pin(audio_irq, 1'b1);
    rd(4'h8, 16'h0002);
    pin(audio_irq, 1'b0);
    wr(4'h2, 16'(rnd()));
    rd(4'h2, 16'h0000);
    // A second reset in mid-run clears the configuration again.
    rst_n <= 1'b0;
    @(posedge mclk);
    rst_n <= 1'b1;
    @(negedge mclk);
    pin(port_en, 1'b0);
    pin(clk_en, 1'b0);
    rd(4'h0, 16'h0000);
    repeat (4) @(posedge mclk);
    cmp(16'(exp_q.size()), 16'h0000);
    end_sim();
  end
endmodule
